// ===== bank_switch_io_decoder.v
// Memory bank controller and I/O select decoder
`timescale 1ns/1ps
`default_nettype none
`include "bank_decoder_defs.vh"
module bank_switch_io_decoder (
  input wire clk,
  input wire reset_n,
  input wire manual_reset_in_n,
  input wire [15:0] cpu_addr,
  input wire cpu_mreq_n,
  input wire cpu_iorq_n,
  input wire cpu_rd_n,
  input wire cpu_wr_n,
  input wire cpu_m1_n,
  input wire compat_mode_select,
  input wire video_std_select,
  input wire mode_320,
  input wire tempo_input,
  input wire hblank_input,
  input wire data_bit0_in,
  output reg [7:0] data_out,
  output reg data_out_en,
  output wire cpu_clock,
  output wire cpu_tick,
  output reg system_reset_out_n,
  output reg upper_bank_inhibit,
  output reg ntsc_timing,
  output reg timer_gate0,
  output wire rom_select_n,
  output wire char_rom_select_n,
  output wire vram_select_n,
  output wire dram_select_n,
  output wire keytimer_select_n,
  output wire pio_select_n,
  output wire sound_gen_select_n,
  output wire joystick_select_n,
  output wire palette_write_n,
  output wire interval_timer_select_n,
  output wire ppi_select_n,
  output wire spare_b0_select_n,
  output wire spare_f4_select_n,
  output wire gated_io_write_n,
  output wire gated_io_read_n
);
  // CPU bus pins and board switches arrive from outside this clock's timing
  localparam SYNC_BITS = 27;
  localparam [SYNC_BITS-1:0] SYNC_RESET = `SYNC_IDLE;
  wire [SYNC_BITS-1:0] sync_in;
  wire [SYNC_BITS-1:0] sync_out;
  assign sync_in = {data_bit0_in, hblank_input, tempo_input, video_std_select, manual_reset_in_n,
                    compat_mode_select, cpu_m1_n, cpu_wr_n, cpu_rd_n, cpu_iorq_n, cpu_mreq_n, cpu_addr};

  // Two flip-flops per bit; reset leaves an idle bus so no false command follows it
  genvar i;
  generate
    for (i = 0; i < SYNC_BITS; i = i + 1) begin : sync_bit
      reg stage1;
      reg stage2;
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1 <= SYNC_RESET[i];
          stage2 <= SYNC_RESET[i];
        end else begin
          stage1 <= sync_in[i];
          stage2 <= stage1; // Only the second stage is read
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

  // Synchronised bus; strobes turned active high
  wire [15:0] addr_s2 = sync_out[15:0];
  wire [4:0] ctl_s2 = sync_out[20:16];
  wire [5:0] pin_s2 = sync_out[26:21];
  wire mreq = ~ctl_s2[0];
  wire iorq = ~ctl_s2[1];
  wire rd = ~ctl_s2[2];
  wire wr = ~ctl_s2[3];
  wire m1 = ~ctl_s2[4];
  wire [15:0] a = addr_s2;
  wire [7:0] port = addr_s2[7:0];
  wire native = pin_s2[0];
  wire manual_n = pin_s2[1];

  cpu_clock_divider u_div (
    .clk(clk),
    .reset_n(reset_n),
    .cpu_clock(cpu_clock),
    .cpu_tick(cpu_tick)
  );

  // Internal reset combines power-on and manual reset
  wire map_reset = ~manual_n;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      system_reset_out_n <= 1'b0;
    end else begin
      system_reset_out_n <= manual_n;
    end
  end

  // Map state: low page ROM, D000+ area in compat, native upper ROM, video window, char ROM, inhibit
  reg low_rom;
  reg upper_io;
  reg upper_rom;
  reg vram_win;
  reg chrom;
  reg inhibit;
  reg io_prev;
  reg next_low_rom;
  reg next_upper_io;
  reg next_upper_rom;
  reg next_vram_win;
  reg next_chrom;
  reg next_inhibit;

  // One command per I/O cycle: act on the leading edge only
  wire io_cycle = iorq & ~m1 & (rd | wr);
  wire io_start = io_cycle & ~io_prev;
  wire bank_hit = io_start && port >= `BANK_PORT_E0 && port <= `BANK_PORT_E6;
  wire bank_out = bank_hit & wr;
  wire bank_in = bank_hit & rd;

  // Next map; a command touches only the areas it names, the rest keep their state
  always @* begin
    next_low_rom = low_rom;
    next_upper_io = upper_io;
    next_upper_rom = upper_rom;
    next_vram_win = vram_win;
    next_chrom = chrom;
    next_inhibit = inhibit;
    if (map_reset) begin
      // Manual reset brings back the native power-on map
      next_low_rom = 1'b1;
      next_upper_io = 1'b0;
      next_upper_rom = 1'b1;
      next_vram_win = 1'b1;
      next_chrom = 1'b0;
      next_inhibit = 1'b0;
    end else if (bank_out) begin
      case (port)
        // Low 32 KB to DRAM; the video window lies above it and stays as it was
        `BANK_PORT_E0: begin
          next_low_rom = 1'b0;
          next_chrom = 1'b0;
        end
        // Upper area to DRAM in either mode
        `BANK_PORT_E1: begin
          next_upper_io = 1'b0;
          next_upper_rom = 1'b0;
        end
        `BANK_PORT_E2: begin
          next_low_rom = 1'b1;
        end
        // Upper ROM in native mode, video and key/timer area in compatibility mode
        `BANK_PORT_E3: begin
          if (native) begin
            next_upper_rom = 1'b1;
          end else begin
            next_upper_io = 1'b1;
          end
        end
        // Power-on map of the current mode
        `BANK_PORT_E4: begin
          next_low_rom = 1'b1;
          next_chrom = 1'b0;
          if (native) begin
            next_vram_win = 1'b1;
            next_upper_rom = 1'b1;
          end else begin
            next_upper_io = 1'b1;
            next_vram_win = 1'b0;
          end
        end
        // The block sits over the upper mapping, which is kept underneath for lifting
        `BANK_PORT_E5: begin
          next_inhibit = 1'b1;
        end
        `BANK_PORT_E6: begin
          next_inhibit = 1'b0;
        end
        default: begin
          next_inhibit = inhibit;
        end
      endcase
    end else if (bank_in) begin
      // 1000-1FFF is always DRAM under the char ROM, so lifting it restores that
      if (port == `BANK_PORT_E0) begin
        next_chrom = 1'b1;
        next_vram_win = 1'b1;
      end else if (port == `BANK_PORT_E1) begin
        next_chrom = 1'b0;
        next_vram_win = 1'b0;
      end
    end
  end

  // Map registers; power-on reset gives the native map
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_rom <= 1'b1;
      upper_io <= 1'b0;
      upper_rom <= 1'b1;
      vram_win <= 1'b1;
      chrom <= 1'b0;
      inhibit <= 1'b0;
      io_prev <= 1'b0;
    end else begin
      low_rom <= next_low_rom;
      upper_io <= next_upper_io;
      upper_rom <= next_upper_rom;
      vram_win <= next_vram_win;
      chrom <= next_chrom;
      inhibit <= next_inhibit;
      io_prev <= io_cycle & ~map_reset; // A cycle standing through manual reset acts once after it
    end
  end

  // Inhibit output shows the block on the upper area
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_bank_inhibit <= 1'b0;
      ntsc_timing <= 1'b0;
    end else begin
      upper_bank_inhibit <= inhibit;
      ntsc_timing <= pin_s2[2];
    end
  end

  // Address decode of the memory cycle to a target
  reg [1:0] target;
  reg keytimer;
  reg blocked;
  always @* begin
    target = `TGT_DRAM;
    keytimer = 1'b0;
    blocked = 1'b0;
    if (a[15:12] == 4'h0 && low_rom) begin
      target = `TGT_ROM;
    end else if (a[15:12] == 4'h1 && chrom) begin
      target = `TGT_CHROM;
    end else if (native) begin
      if (a[15:13] == 3'b111) begin
        if (inhibit) begin
          blocked = 1'b1;
        end else if (upper_rom) begin
          target = `TGT_ROM;
        end
      end else if (a[15:14] == 2'b10 && vram_win) begin
        if (!mode_320 || a[13] == 1'b0) begin
          target = `TGT_VRAM;
        end
      end
    end else begin
      if (a[15:12] >= 4'hd) begin
        if (inhibit) begin
          blocked = 1'b1;
        end else if (upper_io) begin
          if (a[15:12] == 4'hd) begin
            target = `TGT_VRAM;
          end else if (a[15:11] == 5'b11100) begin
            keytimer = 1'b1;
            target = `TGT_DRAM;
          end else begin
            target = `TGT_ROM;
          end
        end
      end else if (a[15:12] == 4'hc && vram_win) begin
        target = `TGT_VRAM;
      end
    end
  end

  wire mem = mreq & (rd | wr) & ~blocked;
  assign rom_select_n = ~(mem & ~keytimer & target == `TGT_ROM);
  assign char_rom_select_n = ~(mem & target == `TGT_CHROM);
  assign vram_select_n = ~(mem & ~keytimer & target == `TGT_VRAM);
  assign dram_select_n = ~(mem & ~keytimer & target == `TGT_DRAM);
  assign keytimer_select_n = ~(mem & keytimer);

  // Timer gate latch and status read at E008, compatibility mode only
  wire e008 = mem & keytimer & ~native & (a == `MEM_TIMER_GATE);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_gate0 <= 1'b0;
      data_out <= 8'h00;
      data_out_en <= 1'b0;
    end else begin
      if (e008 & wr) begin
        timer_gate0 <= pin_s2[5];
      end
      data_out_en <= e008 & rd;
      data_out <= {6'h00, pin_s2[4], pin_s2[3]};
    end
  end

  // I/O select decode; strobes only when a listed port is hit
  wire io = iorq & ~m1;
  wire s_pio = io & (port[7:2] == `IO_PIO_BASE);
  wire s_snd = io & wr & (port == `IO_SOUND);
  wire s_joy = io & rd & (port == `IO_PALETTE || port == `IO_STICK2);
  wire s_pal = io & wr & (port == `IO_PALETTE);
  wire s_tmr = io & (port[7:2] == `IO_TIMER_BASE);
  wire s_ppi = io & (port[7:2] == `IO_PPI_BASE);
  wire s_b0 = io & (port >= `IO_SPARE_B0_LO) & (port <= `IO_SPARE_B0_HI);
  wire s_f4 = io & (port[7:2] == `IO_SPARE_F4_BASE);
  wire s_bank = io & (port >= `BANK_PORT_E0) & (port <= `BANK_PORT_E6);
  wire any_io = s_pio | s_snd | s_joy | s_pal | s_tmr | s_ppi | s_b0 | s_f4 | s_bank;
  assign pio_select_n = ~s_pio;
  assign sound_gen_select_n = ~s_snd;
  assign joystick_select_n = ~s_joy;
  assign palette_write_n = ~s_pal;
  assign interval_timer_select_n = ~s_tmr;
  assign ppi_select_n = ~s_ppi;
  assign spare_b0_select_n = ~s_b0;
  assign spare_f4_select_n = ~s_f4;
  assign gated_io_write_n = ~(any_io & wr);
  assign gated_io_read_n = ~(any_io & rd);
endmodule
`default_nettype wire

// ===== bank_decoder_defs.vh
// Constants for the bank switch and I/O decoder
// Function
// - I/O ports E0..E6 are bank control commands changing the address map.
// - OUT E0 maps 0000-7FFF to DRAM; other areas keep mapping.
// - OUT E1 maps D000-FFFF (compat) or E000-FFFF (native) to DRAM.
// - OUT E2 maps 0000-0FFF to ROM; native OUT E3 maps E000-FFFF to ROM.
// - Compat OUT E3/E4 maps D000-FFFF to video RAM, key/timer, ROM.
// - OUT E4 restores power-on map; native adds video RAM 8000-BFFF, ROM E000-FFFF.
// - In 320x200 mode native video RAM covers 8000-9FFF only; A000-BFFF is DRAM.
// - IN E0 maps 1000-1FFF to char ROM and video window to video RAM.
// - IN E1 restores 1000-1FFF and maps video window to DRAM.
// - OUT E5 blocks upper area and drives bank inhibit high.
// - OUT E6 lifts the block, restoring the previous upper mapping.
// - After reset the native power-on map is presented.
// - Mode select input low selects compatibility mode.
// - PIO chip select active low for I/O FC..FF.
// - F2 write is sound select; F0/F1 reads joystick; F0 write palette.
// - Interval timer select active low for I/O D4..D7.
// - Peripheral interface select active low for I/O D0..D3.
// - Decoded I/O accesses drive gated write or read strobe, active low.
// - Compat mode E008 reads tempo and hblank; writes control timer gate.
// - Spare selects for I/O B0..B4 and F4..F7, active low.
// - Video standard select low is PAL, high is NTSC.
// - Master clock input is divided to give the CPU clock output.
// - CPU clock is master clock divided by five.
`ifndef BANK_DECODER_DEFS_VH
`define BANK_DECODER_DEFS_VH
`define BANK_PORT_E0 8'he0
`define BANK_PORT_E1 8'he1
`define BANK_PORT_E2 8'he2
`define BANK_PORT_E3 8'he3
`define BANK_PORT_E4 8'he4
`define BANK_PORT_E5 8'he5
`define BANK_PORT_E6 8'he6
`define IO_PALETTE 8'hf0
`define IO_STICK2 8'hf1
`define IO_SOUND 8'hf2
`define IO_PIO_BASE 6'h3f
`define IO_TIMER_BASE 6'h35
`define IO_PPI_BASE 6'h34
`define IO_SPARE_F4_BASE 6'h3d
`define IO_SPARE_B0_LO 8'hb0
`define IO_SPARE_B0_HI 8'hb4
`define MEM_TIMER_GATE 16'he008
`define CPU_DIV 3'd5
`define CPU_DIV_HIGH 3'd2
// Synchroniser reset levels: strobes and manual reset released, native mode selected
`define SYNC_IDLE 27'h07f0000
// Target codes for each 4 KB page
`define TGT_DRAM 2'h0
`define TGT_ROM 2'h1
`define TGT_VRAM 2'h2
`define TGT_CHROM 2'h3
`endif

// ===== cpu_clock_divider.v
// Divide-by-five clock generator for the CPU clock
`timescale 1ns/1ps
`default_nettype none
`include "bank_decoder_defs.vh"
module cpu_clock_divider (
  input wire clk,
  input wire reset_n,
  output reg cpu_clock,
  output reg cpu_tick
);
  reg [2:0] count;

  // Counts 0..4; clock is high for two of the five master cycles
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 3'd0;
      cpu_clock <= 1'b0;
      cpu_tick <= 1'b0;
    end else begin
      if (count == `CPU_DIV - 3'd1) begin
        count <= 3'd0;
      end else begin
        count <= count + 3'd1;
      end
      cpu_clock <= (count < `CPU_DIV_HIGH);
      cpu_tick <= (count == 3'd0);
    end
  end
endmodule
`default_nettype wire

// ===== bank_switch_io_decoder_monitor.sv
// Port checker for the bank switch and I/O decoder
`timescale 1ns/1ps
`default_nettype none
module bank_switch_io_decoder_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic manual_reset_in_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_iorq_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic cpu_m1_n,
  input wire logic cpu_clock,
  input wire logic cpu_tick,
  input wire logic system_reset_out_n,
  input wire logic upper_bank_inhibit,
  input wire logic pio_select_n,
  input wire logic interval_timer_select_n,
  input wire logic ppi_select_n,
  input wire logic gated_io_write_n,
  input wire logic gated_io_read_n
);
  // One domain, so clock and reset are stated once
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Divide by five: one tick per period, clock high two cycles of five
  AST_TICK: assert property (cpu_tick |=> !cpu_tick [*4] ##1 cpu_tick)
    else $error("cpu tick spacing wrong");
  AST_CLK_HIGH: assert property ($rose(cpu_clock) |=> cpu_clock ##1 !cpu_clock)
    else $error("cpu clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(cpu_clock) |-> !cpu_clock [*3] ##1 cpu_clock)
    else $error("cpu clock low phase wrong");
  // Manual reset passes a two stage synchroniser before reaching the output
  AST_RST_OUT: assert property (!manual_reset_in_n [*4] |-> !system_reset_out_n)
    else $error("reset output not low");
  // Selects follow the bus two cycles late through the synchroniser
  AST_PIO: assert property ((!cpu_iorq_n && !cpu_rd_n && cpu_m1_n && cpu_addr[7:2] == 6'h3f) [*3]
    |-> !pio_select_n)
    else $error("pio select missing");
  AST_TIMER: assert property (!interval_timer_select_n
    |-> $past(cpu_addr[7:2], 2) == 6'h35 && !$past(cpu_iorq_n, 2))
    else $error("timer select on wrong address");
  AST_PPI: assert property (!ppi_select_n |-> $past(cpu_addr[7:2], 2) == 6'h34 && !$past(cpu_iorq_n, 2))
    else $error("ppi select on wrong address");
  AST_GATED_WR: assert property (!gated_io_write_n |-> !$past(cpu_wr_n, 2))
    else $error("gated write without write");
  AST_GATED_RD: assert property (!gated_io_read_n |-> !$past(cpu_rd_n, 2))
    else $error("gated read without read");
  AST_INHIBIT: assert property ($rose(upper_bank_inhibit)
    |-> $past(cpu_addr[7:0], 3) == 8'he5 && !$past(cpu_wr_n, 3))
    else $error("inhibit raised without its port");
endmodule
bind bank_switch_io_decoder bank_switch_io_decoder_monitor mon_u (.clk, .reset_n, .manual_reset_in_n,
  .cpu_addr, .cpu_iorq_n, .cpu_rd_n, .cpu_wr_n, .cpu_m1_n, .cpu_clock, .cpu_tick, .system_reset_out_n,
  .upper_bank_inhibit, .pio_select_n, .interval_timer_select_n, .ppi_select_n, .gated_io_write_n,
  .gated_io_read_n);
`default_nettype wire

// ===== cpu_bus_model.sv
// CPU bus master model issuing memory and I/O cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic clk,
  output logic [15:0] cpu_addr,
  output logic cpu_mreq_n,
  output logic cpu_iorq_n,
  output logic cpu_rd_n,
  output logic cpu_wr_n,
  output logic cpu_m1_n
);
  // Idle bus from time zero; interrupt acknowledge is never issued
  initial begin
    cpu_addr = 16'hffff;
    cpu_mreq_n = 1'b1;
    cpu_iorq_n = 1'b1;
    cpu_rd_n = 1'b1;
    cpu_wr_n = 1'b1;
    cpu_m1_n = 1'b1;
  end
  // Kind 0 memory read, 1 I/O write, 2 I/O read, 3 memory write
  task automatic go(input logic [15:0] a, input logic [1:0] k);
    @(posedge clk);
    cpu_addr <= a;
    cpu_mreq_n <= k[0] ^ k[1];
    cpu_iorq_n <= k[0] ~^ k[1];
    cpu_rd_n <= k[0];
    cpu_wr_n <= ~k[0];
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Floating address shows the inverse so stale values never look held
  task automatic stop();
    @(posedge clk);
    cpu_addr <= ~cpu_addr;
    cpu_mreq_n <= 1'b1;
    cpu_iorq_n <= 1'b1;
    cpu_rd_n <= 1'b1;
    cpu_wr_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== bank_switch_io_decoder_test.sv
// Self-checking bench for the bank switch and I/O decoder
`timescale 1ns/1ps
`default_nettype none
module bank_switch_io_decoder_test;
  // Memory select patterns {rom, char rom, vram, dram, key timer}, active low
  localparam logic [4:0] ro = 5'h0f, ch = 5'h17, vr = 5'h1b, dr = 5'h1d, kt = 5'h1e, no = 5'h1f;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic manual_reset_in_n = 1'b1, compat_mode_select = 1'b1, video_std_select = 1'b0;
  logic mode_320 = 1'b0, tempo_input = 1'b0, hblank_input = 1'b0, data_bit0_in = 1'b0;
  wire [15:0] cpu_addr;
  wire [7:0] data_out;
  wire cpu_mreq_n, cpu_iorq_n, cpu_rd_n, cpu_wr_n, cpu_m1_n, data_out_en, cpu_clock, cpu_tick;
  wire system_reset_out_n, upper_bank_inhibit, ntsc_timing, timer_gate0, rom_select_n, char_rom_select_n;
  wire vram_select_n, dram_select_n, keytimer_select_n, pio_select_n, sound_gen_select_n, joystick_select_n;
  wire palette_write_n, interval_timer_select_n, ppi_select_n, spare_b0_select_n, spare_f4_select_n;
  wire gated_io_write_n, gated_io_read_n;
  wire [4:0] sel = {rom_select_n, char_rom_select_n, vram_select_n, dram_select_n, keytimer_select_n};
  wire [9:0] io_sel = {pio_select_n, sound_gen_select_n, joystick_select_n, palette_write_n,
    interval_timer_select_n, ppi_select_n, spare_b0_select_n, spare_f4_select_n, gated_io_write_n, gated_io_read_n};
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  cpu_bus_model bus_u (.clk, .cpu_addr, .cpu_mreq_n, .cpu_iorq_n, .cpu_rd_n, .cpu_wr_n, .cpu_m1_n);
  bank_switch_io_decoder dut_u (.clk, .reset_n, .manual_reset_in_n, .cpu_addr, .cpu_mreq_n, .cpu_iorq_n,
    .cpu_rd_n, .cpu_wr_n, .cpu_m1_n, .compat_mode_select, .video_std_select, .mode_320, .tempo_input,
    .hblank_input, .data_bit0_in, .data_out, .data_out_en, .cpu_clock, .cpu_tick, .system_reset_out_n,
    .upper_bank_inhibit, .ntsc_timing, .timer_gate0, .rom_select_n, .char_rom_select_n, .vram_select_n,
    .dram_select_n, .keytimer_select_n, .pio_select_n, .sound_gen_select_n, .joystick_select_n,
    .palette_write_n, .interval_timer_select_n, .ppi_select_n, .spare_b0_select_n, .spare_f4_select_n,
    .gated_io_write_n, .gated_io_read_n);
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  // Run needs under a thousand cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic mem(input logic [15:0] a, input logic [4:0] e);
    bus_u.go(a, 2'd0);
    chk(sel, e);
    bus_u.stop();
  endtask
  task automatic io(input logic [15:0] a, input logic [1:0] k);
    bus_u.go(a, k);
    bus_u.stop();
  endtask
  task automatic t_native();
    io(16'h00e0, 2'd1);
    mem(16'h0000, dr);
    mem(16'he000, ro);
    mem(16'h8000, vr);
    data_bit0_in <= 1'b1;
    io(16'h00e1, 2'd1);
    mem(16'he000, dr);
    mem(16'hd000, dr);
    io(16'h00e2, 2'd1);
    mem(16'h0000, ro);
    io(16'h00e3, 2'd1);
    mem(16'hf000, ro);
    io(16'h00e0, 2'd2);
    mem(16'h1000, ch);
    mem(16'h8000, vr);
    io(16'h00e1, 2'd2);
    mem(16'h1000, dr);
    mem(16'hb000, dr);
  endtask
  // Blocked upper area answers with no select at all
  task automatic t_inhibit();
    io(16'h00e5, 2'd1);
    chk(upper_bank_inhibit, 1'b1);
    mem(16'he000, no);
    io(16'h00e6, 2'd1);
    chk(upper_bank_inhibit, 1'b0);
    mem(16'he000, ro);
  endtask
  task automatic t_320();
    mode_320 <= 1'b1;
    io(16'h00e4, 2'd1);
    mem(16'h9000, vr);
    mem(16'ha000, dr);
    mem(16'h0000, ro);
    mem(16'he000, ro);
    mode_320 <= 1'b0;
  endtask
  // Kind is taken from the expected read strobe bit
  task automatic t_io();
    logic [7:0] a [15] = '{8'hfc, 8'hff, 8'hf2, 8'hf0, 8'hf1, 8'hf0, 8'hd4, 8'hd7, 8'hd0, 8'hd3,
      8'hb0, 8'hb4, 8'hf4, 8'hf7, 8'hb5};
    logic [9:0] e [15] = '{10'h1fd, 10'h1fe, 10'h2fd, 10'h37e, 10'h37e, 10'h3bd, 10'h3dd, 10'h3de,
      10'h3ed, 10'h3ee, 10'h3f5, 10'h3f6, 10'h3f9, 10'h3fa, 10'h3ff};
    for (int i = 0; i < 15; i++) begin
      bus_u.go({8'h00, a[i]}, e[i][0] ? 2'd1 : 2'd2);
      chk(io_sel, e[i]);
      bus_u.stop();
    end
  endtask
  task automatic t_compat();
    reset_n <= 1'b0;
    compat_mode_select <= 1'b0;
    hblank_input <= 1'b1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    io(16'h00e4, 2'd1);
    mem(16'h1000, dr);
    mem(16'hd000, vr);
    mem(16'he000, kt);
    mem(16'hf000, ro);
    bus_u.go(16'he008, 2'd0);
    chk({data_out_en, data_out[1:0]}, 3'b110);
    bus_u.stop();
    io(16'he008, 2'd3);
    chk(timer_gate0, 1'b1);
    data_bit0_in <= 1'b0;
    io(16'he008, 2'd3);
    chk(timer_gate0, 1'b0);
    io(16'h00e1, 2'd1);
    mem(16'hd000, dr);
    io(16'h00e0, 2'd2);
    mem(16'hc000, vr);
    io(16'h00e1, 2'd2);
    mem(16'hc000, dr);
  endtask
  task automatic t_misc();
    video_std_select <= 1'b1;
    io(16'h00e0, 2'd1);
    chk(ntsc_timing, 1'b1);
    manual_reset_in_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(system_reset_out_n, 1'b0);
    manual_reset_in_n <= 1'b1;
    repeat (6) @(posedge clk);
    mem(16'h0000, ro);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    chk(system_reset_out_n, 1'b0);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    mem(16'h0000, ro);
    mem(16'h8000, vr);
    t_native();
    t_inhibit();
    t_320();
    t_io();
    t_compat();
    t_misc();
    print_verdict();
  end
endmodule
`default_nettype wire
